// *** scb_regs.vh ***
// Register offsets, field positions and reset values of the system control block
`ifndef SCB_REGS_VH
`define SCB_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCB_OFF_CORE_ID      8'h00
`define SCB_OFF_INT_STATE    8'h04
`define SCB_OFF_VEC_BASE     8'h08
`define SCB_OFF_APP_RESET    8'h0c
`define SCB_OFF_SLEEP        8'h10
`define SCB_OFF_CONFIG       8'h14
`define SCB_OFF_PRIO_TWO     8'h1c
`define SCB_OFF_PRIO_THREE   8'h20
`define SCB_OFF_HSTATE       8'h24
`define SCB_OFF_EVT_STATUS   8'h40
`define SCB_OFF_EVT_MASK     8'h44

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCB_RST_APP_RESET    32'hfa058000
`define SCB_RST_CONFIG       32'h00000208
`define SCB_RST_ZERO         32'h00000000

// ----------------------------------------------------------------
// Interrupt state register fields
// ----------------------------------------------------------------
`define SCB_IS_NMI_SET       31
`define SCB_IS_DSC_SET       28
`define SCB_IS_DSC_CLR       27
`define SCB_IS_TICK_SET      26
`define SCB_IS_TICK_CLR      25
`define SCB_IS_ANY_PEND      22
`define SCB_IS_PEND_LSB      12
`define SCB_IS_ACT_LSB       0

// ----------------------------------------------------------------
// Application reset control fields
// ----------------------------------------------------------------
`define SCB_AR_KEY_LSB       16
`define SCB_AR_KEY           16'h05fa
`define SCB_AR_RESET_REQ     2
`define SCB_AR_CLR_ACTIVE    1

// ----------------------------------------------------------------
// Sleep control fields and other masks
// ----------------------------------------------------------------
`define SCB_SLEEP_MASK       32'h00000016
`define SCB_SLEEP_EXIT       1
`define SCB_SLEEP_DEEP       2
`define SCB_SLEEP_ONPEND     4
`define SCB_VEC_MASK         32'hffffff80
`define SCB_PRIO2_LSB        30
`define SCB_PRIO3_TICK_LSB   30
`define SCB_PRIO3_DSC_LSB    22
`define SCB_HS_SVC_PEND      15

// ----------------------------------------------------------------
// Exception vector numbers
// ----------------------------------------------------------------
`define SCB_VEC_NMI          6'h02
`define SCB_VEC_SVC          6'h0b
`define SCB_VEC_DSC          6'h0e
`define SCB_VEC_TICK         6'h0f

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define SCB_EV_RESET_REQ     0
`define SCB_EV_SLEEP         1
`define SCB_EV_UNALIGNED     2
`define SCB_EV_WIDTH         3

`endif

// *** scb_top.v ***
// System control block with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "scb_regs.vh"

module scb_top #(
    parameter [31:0] CORE_ID = 32'h00c0ffee   // Arbitrary identity value
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        debug_halted,        // Core in debug halt, same clock
    input  wire [5:0]  active_vector,       // Active exception vector, same clock
    input  wire        svc_raise,           // Supervisor call taken pending
    input  wire        nmi_taken,           // Core entered non-maskable handler
    input  wire        unaligned_access,    // Core made an unaligned access
    output reg         nmi_pending,         // Non-maskable exception pending
    output reg         dsc_pending,         // Deferred service call pending
    output reg         tick_pending,        // Tick exception pending
    output reg         svc_pending,         // Supervisor call pending
    output reg         hard_fault_req,      // Severe fault request
    output reg         sys_reset_req,       // System reset request pulse
    output reg         clear_active_req,    // Clear active state pulse
    output reg  [31:0] vector_base,         // Vector table base
    output reg         sleep_on_exit,       // Sleep after handler return
    output reg         sleep_deep,          // Deep low-power selected
    output reg         wake_on_pend,        // Pending event wakes the core
    output reg  [1:0]  prio_svc,            // Supervisor call priority
    output reg  [1:0]  prio_dsc,            // Deferred call priority
    output reg  [1:0]  prio_tick,           // Tick priority
    output wire        irq                  // Event interrupt level
);

    // ----------------------------------------------------------------
    // Bus handshake, event, halt and decode state
    // ----------------------------------------------------------------
    reg         aw_held;        // Write address captured
    reg  [7:0]  aw_addr;        // Captured write address
    reg         w_held;         // Write data captured
    reg  [31:0] w_data;         // Captured write data
    reg  [3:0]  w_strb;         // Captured byte enables
    reg  [`SCB_EV_WIDTH-1:0] evt_status;  // Sticky events
    reg  [`SCB_EV_WIDTH-1:0] evt_mask;    // Event enables
    reg         halted_q;       // Previous debug halt level
    reg         clr_armed;      // Clear waiting for halt exit
    reg  [31:0] rd_word;        // Read mux result
    reg         rd_ok;          // Read address decoded
    reg  [5:0]  top_pend;       // Highest pending vector

    // Write decode
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire full_word = (w_strb == 4'hf) && (aw_addr[1:0] == 2'b00);
    wire wr_ok = (aw_addr == `SCB_OFF_INT_STATE)
              || (aw_addr == `SCB_OFF_VEC_BASE)
              || (aw_addr == `SCB_OFF_APP_RESET)
              || (aw_addr == `SCB_OFF_SLEEP)
              || (aw_addr == `SCB_OFF_PRIO_TWO)
              || (aw_addr == `SCB_OFF_PRIO_THREE)
              || (aw_addr == `SCB_OFF_HSTATE)
              || (aw_addr == `SCB_OFF_EVT_STATUS)
              || (aw_addr == `SCB_OFF_EVT_MASK)
              || (aw_addr == `SCB_OFF_CORE_ID)
              || (aw_addr == `SCB_OFF_CONFIG);
    wire wr_go = do_write && full_word;
    wire wr_is = wr_go && (aw_addr == `SCB_OFF_INT_STATE);
    wire wr_ar = wr_go && (aw_addr == `SCB_OFF_APP_RESET)
              && (w_data[31:`SCB_AR_KEY_LSB] == `SCB_AR_KEY);
    wire [`SCB_EV_WIDTH-1:0] evt_in;

    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq = |(evt_status & evt_mask);

    // Event sources, one per status bit
    assign evt_in[`SCB_EV_RESET_REQ] = wr_ar && w_data[`SCB_AR_RESET_REQ];
    assign evt_in[`SCB_EV_SLEEP]     = 1'b0;   // Spare bit
    assign evt_in[`SCB_EV_UNALIGNED] = unaligned_access;

    // ----------------------------------------------------------------
    // Write channels and response
    // ----------------------------------------------------------------
    // Address and data taken in either order, answer after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            // Address channel
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end

            // Data channel
            if (s_axi_wvalid && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end

            // Response once both are held
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ok && full_word) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software-held configuration
    // ----------------------------------------------------------------
    // Vector base, sleep settings and priorities
    always @(posedge aclk) begin
        if (!aresetn) begin
            vector_base   <= `SCB_RST_ZERO;
            sleep_on_exit <= 1'b0;
            sleep_deep    <= 1'b0;
            wake_on_pend  <= 1'b0;
            prio_svc      <= 2'b00;
            prio_dsc      <= 2'b00;
            prio_tick     <= 2'b00;
            evt_mask      <= {`SCB_EV_WIDTH{1'b0}};
        end else if (wr_go) begin
            case (aw_addr)
                `SCB_OFF_VEC_BASE: begin
                    vector_base <= w_data & `SCB_VEC_MASK;
                end
                `SCB_OFF_SLEEP: begin
                    sleep_on_exit <= w_data[`SCB_SLEEP_EXIT];
                    sleep_deep    <= w_data[`SCB_SLEEP_DEEP];
                    wake_on_pend  <= w_data[`SCB_SLEEP_ONPEND];
                end
                `SCB_OFF_PRIO_TWO: begin
                    prio_svc <= w_data[`SCB_PRIO2_LSB +: 2];
                end
                `SCB_OFF_PRIO_THREE: begin
                    prio_tick <= w_data[`SCB_PRIO3_TICK_LSB +: 2];
                    prio_dsc  <= w_data[`SCB_PRIO3_DSC_LSB +: 2];
                end
                `SCB_OFF_EVT_MASK: begin
                    evt_mask <= w_data[`SCB_EV_WIDTH-1:0];
                end
                default: begin
                    evt_mask <= evt_mask;   // Identity and fixed words ignore writes
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pending exception state
    // ----------------------------------------------------------------
    // Updated the cycle after the write; set wins over clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            nmi_pending  <= 1'b0;
            dsc_pending  <= 1'b0;
            tick_pending <= 1'b0;
            svc_pending  <= 1'b0;
        end else begin
            // Non-maskable, cleared when taken
            if (wr_is && w_data[`SCB_IS_NMI_SET])
                nmi_pending <= 1'b1;
            else if (nmi_taken)
                nmi_pending <= 1'b0;

            // Deferred call
            if (wr_is && w_data[`SCB_IS_DSC_SET])
                dsc_pending <= 1'b1;
            else if (wr_is && w_data[`SCB_IS_DSC_CLR])
                dsc_pending <= 1'b0;

            // Tick
            if (wr_is && w_data[`SCB_IS_TICK_SET])
                tick_pending <= 1'b1;
            else if (wr_is && w_data[`SCB_IS_TICK_CLR])
                tick_pending <= 1'b0;

            // Supervisor call
            if (svc_raise)
                svc_pending <= 1'b1;                        // Set wins over clear
            else if (wr_go && aw_addr == `SCB_OFF_HSTATE)
                svc_pending <= w_data[`SCB_HS_SVC_PEND];
        end
    end

    // ----------------------------------------------------------------
    // Reset request, halt-exit clear, faults and events
    // ----------------------------------------------------------------
    // Keyed control writes; clear fires when debug halt ends
    always @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset_req    <= 1'b0;
            clear_active_req <= 1'b0;
            clr_armed        <= 1'b0;
            halted_q         <= 1'b0;
            hard_fault_req   <= 1'b0;
            evt_status       <= {`SCB_EV_WIDTH{1'b0}};
        end else begin
            halted_q       <= debug_halted;
            sys_reset_req  <= wr_ar && w_data[`SCB_AR_RESET_REQ];
            hard_fault_req <= unaligned_access;

            // Clear armed in halt, fires at exit
            if (wr_ar && w_data[`SCB_AR_CLR_ACTIVE] && debug_halted)
                clr_armed <= 1'b1;
            else if (halted_q && !debug_halted)
                clr_armed <= 1'b0;
            clear_active_req <= clr_armed && halted_q && !debug_halted;

            // Sticky events, new event wins over write-one clear
            if (wr_go && aw_addr == `SCB_OFF_EVT_STATUS)
                evt_status <= (evt_status & ~w_data[`SCB_EV_WIDTH-1:0]) | evt_in;
            else
                evt_status <= evt_status | evt_in;
        end
    end

    // ----------------------------------------------------------------
    // Highest pending vector
    // ----------------------------------------------------------------
    // Order: non-maskable, supervisor, then deferred or tick by lower priority level
    always @* begin
        if (nmi_pending)
            top_pend = `SCB_VEC_NMI;
        else if (svc_pending)
            top_pend = `SCB_VEC_SVC;
        // Equal levels favour the deferred call
        else if (dsc_pending && (!tick_pending || prio_dsc <= prio_tick))
            top_pend = `SCB_VEC_DSC;
        else if (tick_pending)
            top_pend = `SCB_VEC_TICK;
        else
            top_pend = 6'h00;
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    // Unmapped offsets answer with an error and zero data
    always @* begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            `SCB_OFF_CORE_ID:    rd_word = CORE_ID;
            `SCB_OFF_INT_STATE: begin
                rd_word[`SCB_IS_NMI_SET]  = nmi_pending;
                rd_word[`SCB_IS_DSC_SET]  = dsc_pending;
                rd_word[`SCB_IS_TICK_SET] = tick_pending;
                rd_word[`SCB_IS_ANY_PEND] = |top_pend;
                rd_word[`SCB_IS_PEND_LSB +: 6] = top_pend;
                rd_word[`SCB_IS_ACT_LSB +: 6]  = active_vector;
            end
            `SCB_OFF_VEC_BASE:   rd_word = vector_base;
            `SCB_OFF_APP_RESET:  rd_word = `SCB_RST_APP_RESET;
            `SCB_OFF_SLEEP: begin
                rd_word[`SCB_SLEEP_EXIT]   = sleep_on_exit;
                rd_word[`SCB_SLEEP_DEEP]   = sleep_deep;
                rd_word[`SCB_SLEEP_ONPEND] = wake_on_pend;
            end
            `SCB_OFF_CONFIG:     rd_word = `SCB_RST_CONFIG;
            `SCB_OFF_PRIO_TWO:   rd_word[`SCB_PRIO2_LSB +: 2] = prio_svc;
            `SCB_OFF_PRIO_THREE: begin
                rd_word[`SCB_PRIO3_TICK_LSB +: 2] = prio_tick;
                rd_word[`SCB_PRIO3_DSC_LSB +: 2]  = prio_dsc;
            end
            `SCB_OFF_HSTATE:     rd_word[`SCB_HS_SVC_PEND] = svc_pending;
            `SCB_OFF_EVT_STATUS: rd_word[`SCB_EV_WIDTH-1:0] = evt_status;
            `SCB_OFF_EVT_MASK:   rd_word[`SCB_EV_WIDTH-1:0] = evt_mask;
            default:             rd_ok = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    // One read in flight, data registered
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            // Address taken, data registered
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            // Master took the data
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** scb_top_asserts.sv ***
// Concurrent checks on the ports of the system control block
`timescale 1ns/1ps
`default_nettype none
module scb_top_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        nmi_taken,
    input wire logic        unaligned_access,
    input wire logic        nmi_pending,
    input wire logic        dsc_pending,
    input wire logic        tick_pending,
    input wire logic        hard_fault_req,
    input wire logic        sys_reset_req,
    input wire logic [31:0] vector_base,
    input wire logic        sleep_deep,
    input wire logic [1:0]  prio_svc,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Helper: write taken; its effect shows two edges later
    // ------------------------------------------------------------
    logic wr_go;  // Write accepted this edge
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                   && (s_axi_wstrb == 4'hf);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_nmi_set: assert property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wdata[31]
        && !nmi_taken |-> ##2 nmi_pending) else $error("nmi not pending after set");
    a_dsc_set: assert property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wdata[28]
        && !s_axi_wdata[27] |-> ##2 dsc_pending) else $error("deferred call not pending");
    a_tick_clear: assert property (wr_go && s_axi_awaddr == 8'h04 && s_axi_wdata[25]
        && !s_axi_wdata[26] |-> ##2 !tick_pending) else $error("tick pending not cleared");
    a_vec_store: assert property (wr_go && s_axi_awaddr == 8'h08
        |-> ##2 vector_base == ($past(s_axi_wdata, 2) & 32'hffffff80))
        else $error("vector base");
    a_sleep_store: assert property (wr_go && s_axi_awaddr == 8'h10
        |-> ##2 sleep_deep == $past(s_axi_wdata[2], 2)) else $error("deep sleep setting");
    a_prio_store: assert property (wr_go && s_axi_awaddr == 8'h1c
        |-> ##2 prio_svc == $past(s_axi_wdata[31:30], 2)) else $error("svc priority");
    a_reset_request: assert property (wr_go && s_axi_awaddr == 8'h0c
        && s_axi_wdata[31:16] == 16'h05fa && s_axi_wdata[2] |-> ##2 sys_reset_req)
        else $error("keyed reset request missing");
    a_reset_pulse: assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    a_fault_follow: assert property (hard_fault_req == $past(unaligned_access))
        else $error("fault request does not follow unaligned access");

    // Main scenarios reached
    c_reset_req: cover property (sys_reset_req);
    c_fault: cover property (hard_fault_req);
    c_irq: cover property (irq);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind scb_top scb_top_asserts u_scb_top_asserts (.*);
`default_nettype wire

// *** test_scb_top.sv ***
// Self-checking testbench for the system control block
`timescale 1ns/1ps
`default_nettype none
module test_scb_top;
    localparam [31:0] ID_VAL = 32'h5a5a0001;  // Arbitrary identity value
    localparam [31:0] ALL    = 32'hffffffff;  // Compare every bit
    localparam [1:0]  OK     = 2'b00;         // Okay response
    localparam [1:0]  ERR    = 2'b10;         // Slave error response
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        debug_halted = 1'b0, svc_raise = 1'b0, nmi_taken = 1'b0;
    logic        unaligned_access = 1'b0;
    logic [5:0]  active_vector = 6'h00;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, prio_svc, prio_dsc, prio_tick;
    logic [31:0] s_axi_rdata, vector_base;
    logic        nmi_pending, dsc_pending, tick_pending, svc_pending, hard_fault_req;
    logic        sys_reset_req, clear_active_req, sleep_on_exit, sleep_deep, wake_on_pend, irq;
    logic [31:0] rst_seen = 32'h0, clr_seen = 32'h0;  // Pulse counters
    integer      fails = 0, checks_done = 0;

    scb_top #(.CORE_ID(ID_VAL)) u_scb_top (.*);

    always #12.5 aclk = ~aclk;

    // Count one-cycle request pulses
    always @(posedge aclk) begin
        rst_seen <= rst_seen + {31'h0, sys_reset_req};
        clr_seen <= clr_seen + {31'h0, clear_active_req};
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            $display("wrong value at %0t ns: %s got %h expected %h", $time, m, g, e);
            fails++;
        end
    endtask

    // Write one word and check the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic pa, pw, pb, ta, tw, tb;
        logic [1:0] rs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        {pa, pw, pb} = 3'b111;
        while (pa || pw || pb) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            tb = pb && s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            {pa, pw, pb} = {pa && !ta, pw && !tw, pb && !tb};
        end
        chk({30'h0, rs}, {30'h0, er}, "write response");
    endtask

    // Read one word, check data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k,
                      input logic [1:0] er);
        logic pa, ta, tr;
        logic [31:0] dv;
        logic [1:0] rs;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        {pa, tr} = 2'b10;
        while (!tr) begin
            @(negedge aclk);
            ta = pa && s_axi_arready;
            tr = s_axi_rvalid;
            dv = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            pa = pa && !ta;
        end
        chk(dv & k, e, "read data");
        chk({30'h0, rs}, {30'h0, er}, "read response");
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_map;
        rd(8'h00, ID_VAL, ALL, OK);
        rd(8'h04, 32'h0, ALL, OK);
        rd(8'h08, 32'h0, ALL, OK);
        rd(8'h0c, 32'hfa058000, ALL, OK);
        rd(8'h10, 32'h0, ALL, OK);
        rd(8'h14, 32'h00000208, ALL, OK);
        rd(8'h1c, 32'h0, ALL, OK);
        rd(8'h20, 32'h0, ALL, OK);
        rd(8'h24, 32'h0, ALL, OK);
        rd(8'h18, 32'h0, 32'h0, ERR);
        $display("test reset_map finished");
    endtask

    task automatic t_read_only;
        wr(8'h00, ALL, 4'hf, OK);
        wr(8'h14, 32'h0, 4'hf, OK);
        wr(8'h08, ALL, 4'h3, ERR);
        wr(8'h0a, ALL, 4'hf, ERR);
        rd(8'h30, 32'h0, ALL, ERR);
        rd(8'h00, ID_VAL, ALL, OK);
        rd(8'h14, 32'h00000208, ALL, OK);
        rd(8'h08, 32'h0, ALL, OK);
        $display("test read_only finished");
    endtask

    task automatic t_pending;
        wr(8'h04, 32'h14000000, 4'hf, OK);
        @(negedge aclk);
        chk({30'h0, dsc_pending, tick_pending}, 32'h3, "set pending");
        rd(8'h04, 32'h0040e000, 32'h0043f000, OK);
        wr(8'h20, 32'h40800000, 4'hf, OK);
        rd(8'h04, 32'h0040f000, 32'h0043f000, OK);
        chk({28'h0, prio_tick, prio_dsc}, 32'h6, "handler priorities");
        wr(8'h04, 32'h0a000000, 4'hf, OK);
        rd(8'h04, 32'h0, 32'h0043f000, OK);
        wr(8'h04, 32'h80000000, 4'hf, OK);
        rd(8'h04, 32'h00402000, 32'h0043f000, OK);
        @(posedge aclk) nmi_taken <= 1'b1;
        @(posedge aclk) nmi_taken <= 1'b0;
        active_vector <= 6'h0f;
        @(negedge aclk);
        chk({31'h0, nmi_pending}, 32'h0, "nmi taken");
        rd(8'h04, 32'h0000000f, 32'h0000003f, OK);
        $display("test pending finished");
    endtask

    task automatic t_settings;
        wr(8'h08, ALL, 4'hf, OK);
        rd(8'h08, 32'hffffff80, ALL, OK);
        wr(8'h10, 32'h00000016, 4'hf, OK);
        rd(8'h10, 32'h00000016, ALL, OK);
        wr(8'h1c, 32'hc0000000, 4'hf, OK);
        rd(8'h1c, 32'hc0000000, ALL, OK);
        @(negedge aclk);
        chk(vector_base, 32'hffffff80, "vector base");
        chk({29'h0, sleep_on_exit, sleep_deep, wake_on_pend}, 32'h7, "sleep");
        chk({30'h0, prio_svc}, 32'h3, "svc priority");
        $display("test settings finished");
    endtask

    task automatic t_svc;
        @(posedge aclk) svc_raise <= 1'b1;
        @(posedge aclk) svc_raise <= 1'b0;
        rd(8'h24, 32'h00008000, ALL, OK);
        wr(8'h24, 32'h0, 4'hf, OK);
        rd(8'h24, 32'h0, ALL, OK);
        chk({31'h0, svc_pending}, 32'h0, "svc cleared");
        $display("test svc finished");
    endtask

    task automatic t_app_reset;
        wr(8'h0c, 32'h00000004, 4'hf, OK);
        wr(8'h0c, 32'h05fa0004, 4'hf, OK);
        repeat (2) @(posedge aclk);
        chk(rst_seen, 32'h1, "reset request count");
        debug_halted <= 1'b1;
        wr(8'h0c, 32'h05fa0002, 4'hf, OK);
        repeat (3) @(posedge aclk);
        chk(clr_seen, 32'h0, "clear while halted");
        debug_halted <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(clr_seen, 32'h1, "clear at halt exit");
        rd(8'h0c, 32'hfa058000, ALL, OK);
        $display("test app_reset finished");
    endtask

    task automatic t_events;
        wr(8'h40, 32'h00000007, 4'hf, OK);
        @(posedge aclk) unaligned_access <= 1'b1;
        @(posedge aclk) unaligned_access <= 1'b0;
        @(negedge aclk);
        chk({31'h0, hard_fault_req}, 32'h1, "fault request");
        rd(8'h40, 32'h4, 32'h5, OK);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(8'h44, 32'h4, 4'hf, OK);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(8'h40, 32'h4, 4'hf, OK);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd(8'h40, 32'h0, 32'h4, OK);
        $display("test events finished");
    endtask
    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_map;
        t_read_only;
        t_pending;
        t_settings;
        t_svc;
        t_app_reset;
        t_events;
        test_done;
    end

    // Hang guard, far beyond the test length
    initial begin
        repeat (5000) @(posedge aclk);
        fails++;
        test_done;
    end
endmodule
`default_nettype wire
